// ===== include/llst_regs.svh
`ifndef LLST_REGS_SVH
`define LLST_REGS_SVH

// Host register byte offsets.
`define LLST_SYS_CTRL_OFS 4'h0
`define LLST_BYTE_COUNT_OFS 4'h8

// Reset values.
`define LLST_SYS_CTRL_RST 16'h0000
`define LLST_BYTE_COUNT_RST 16'h0000

// Core self-test patterns; all ones is 177777 octal.
`define LLST_PAT_ONES 16'hFFFF
`define LLST_PAT_ZERO 16'h0000

// Channel and adaptor geometry.
`define LLST_CHANNELS 64
`define LLST_ADAPTORS 8
`define LLST_LAST_CHAN 6'h3F

// Selector field encoding, two bits per adaptor.
`define LLST_SEL_OFF 2'h0
`define LLST_SEL_INT 2'h1
`define LLST_SEL_EXT 2'h2

// Timing.
`define LLST_CLK_HZ 40000000
`define LLST_CLK_PERIOD_NS 25
`define LLST_ECHO_BAUD 9600
`define LLST_ECHO_DIV (`LLST_CLK_HZ / `LLST_ECHO_BAUD)
`define LLST_REPLY_TIMEOUT_NS 2000
`define LLST_REPLY_TIMEOUT_CYC (`LLST_REPLY_TIMEOUT_NS / `LLST_CLK_PERIOD_NS)
`define LLST_SEL_SAMPLE_US 1000
`define LLST_SEL_SAMPLE_CYC (`LLST_SEL_SAMPLE_US * 1000 / `LLST_CLK_PERIOD_NS)

`endif

// ===== include/llst_pkg.sv
package llst_pkg;

    typedef enum logic [2:0] {
        LLST_ST_IDLE = 3'h0,
        LLST_ST_CORE = 3'h1,
        LLST_ST_LINES = 3'h3,
        LLST_ST_EVAL = 3'h2,
        LLST_ST_RUN = 3'h6,
        LLST_ST_HANG = 3'h7
    } llst_state_t;

    typedef enum logic [1:0] {
        LLST_LOOP_NONE = 2'h0,
        LLST_LOOP_INT = 2'h1,
        LLST_LOOP_EXT = 2'h2,
        LLST_LOOP_ECHO = 2'h3
    } llst_loop_t;

endpackage : llst_pkg

// ===== logic/llst_chan_check.sv
`timescale 1ns/1ps
`include "llst_regs.svh"

module llst_chan_check (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input llst_pkg::llst_loop_t mode_i,
    input wire logic [7:0] char_i,
    input wire logic rx_strobe_i,
    input wire logic [7:0] rx_char_i,
    output logic tx_strobe_o,
    output logic [7:0] tx_char_o,
    output logic done_o,
    output logic pass_o
);
    import llst_pkg::*;

    localparam logic [15:0] TIMEOUT = 16'(`LLST_REPLY_TIMEOUT_CYC);

    logic busy;
    logic echo;
    logic [7:0] expect_char;
    logic [15:0] wait_cnt;

    // Sends one character and compares the returned one, or in echo mode sends back the one received; times out otherwise.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            busy <= 1'b0;
            echo <= 1'b0;
            expect_char <= 8'h00;
            wait_cnt <= 16'h0000;
            tx_strobe_o <= 1'b0;
            tx_char_o <= 8'h00;
            done_o <= 1'b0;
            pass_o <= 1'b0;
        end else begin
            tx_strobe_o <= 1'b0;
            done_o <= 1'b0;
            if (!busy && start_i) begin
                busy <= 1'b1;
                wait_cnt <= 16'h0000;
                echo <= (mode_i == LLST_LOOP_ECHO);
                expect_char <= char_i;
                if (mode_i != LLST_LOOP_ECHO) begin
                    tx_strobe_o <= 1'b1;
                    tx_char_o <= char_i;
                end
            end else if (busy) begin
                if (rx_strobe_i) begin
                    busy <= 1'b0;
                    done_o <= 1'b1;
                    pass_o <= echo || (rx_char_i == expect_char);
                    if (echo) begin
                        tx_strobe_o <= 1'b1;
                        tx_char_o <= rx_char_i;
                    end
                end else if (wait_cnt == TIMEOUT - 16'h0001) begin
                    busy <= 1'b0;
                    done_o <= 1'b1;
                    pass_o <= echo;
                end else begin
                    wait_cnt <= wait_cnt + 16'h0001;
                end
            end
        end
    end

endmodule : llst_chan_check

// ===== logic/llst_top.sv
`timescale 1ns/1ps
`include "llst_regs.svh"

// How it works
// - Self-test starts on power, not bus initialise.
// - Core test pass turns board lamp off.
// - Core failure keeps lamp lit, ignores host.
// - Power-up tests lines; failing lamps and summary lit.
// - Override off and line failure hangs device.
// - Override on: lamp lit, runs, no summary.
// - Missing adaptor reports line faults.
// - Core failure hangs regardless of override.
// - Byte count register reads back all ones.
// - Power-up internal loop test on every channel.
// - Internal position loops each channel, char by char.
// - Lamp set on mismatch, cleared on success.
// - Hard error lamp stays lit after selector off.
// - Online tests spare other adaptors, never hang.
// - External, no loop path: echo at 9600 baud.
// - External with plug sensed: external loopback instead.
// - External loop: lamp on missing/wrong, clear otherwise.
// - Current loop external test transmits continuously; no line type is sensed here, each external send waits for reply or timeout.
// - Moving selector to internal clears adaptor lamps.

module llst_top #(
    parameter int unsigned SEL_SAMPLE_CYCLES = `LLST_SEL_SAMPLE_CYC
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic power_good_i,
    input wire logic bus_init_i,
    input wire logic core_fault_i,
    input wire logic line_fault_override_i,
    input wire logic [15:0] selector_i,
    input wire logic [63:0] plug_detect_i,
    input wire logic host_sel_i,
    input wire logic host_we_i,
    input wire logic [3:0] host_addr_i,
    input wire logic [15:0] host_wdata_i,
    input wire logic rx_strobe_i,
    input wire logic [7:0] rx_char_i,
    output logic host_ack_o,
    output logic [15:0] host_rdata_o,
    output logic [5:0] chan_o,
    output llst_pkg::llst_loop_t loop_mode_o,
    output logic [15:0] baud_div_o,
    output logic tx_strobe_o,
    output logic [7:0] tx_char_o,
    output logic [63:0] chan_lamp_o,
    output logic board_fault_lamp_o,
    output logic summary_fault_lamp_o,
    output logic running_o,
    output logic hung_o
);
    import llst_pkg::*;

    localparam logic [15:0] ECHO_DIV = 16'(`LLST_ECHO_DIV);
    localparam logic [31:0] SAMPLE_LAST = 32'(SEL_SAMPLE_CYCLES - 1);

    llst_state_t state;
    llst_state_t next_state;
    logic power_q;
    logic [1:0] core_step;
    logic [15:0] system_control_reg;
    logic [15:0] byte_count_reg;
    logic [5:0] chan;
    logic [7:0] test_char;
    logic pending;
    logic start;
    llst_loop_t start_mode;
    logic chk_done;
    logic chk_pass;
    logic [15:0] sel_q;
    logic [31:0] sample_cnt;
    logic sample_now;
    logic [7:0] clear_adaptor;
    logic core_ok;

    function automatic logic [2:0] adaptor_of(input logic [5:0] ch);
        adaptor_of = ch[5:3];
    endfunction : adaptor_of

    function automatic logic [1:0] sel_of(input logic [15:0] sel,
                                          input logic [2:0] ad);
        sel_of = sel[{ad, 1'b0} +: 2];
    endfunction : sel_of

    function automatic llst_loop_t mode_for(input logic [1:0] sel,
                                            input logic plug);
        if (sel == `LLST_SEL_INT) begin
            mode_for = LLST_LOOP_INT;
        end else if (sel == `LLST_SEL_EXT) begin
            mode_for = plug ? LLST_LOOP_EXT : LLST_LOOP_ECHO;
        end else begin
            mode_for = LLST_LOOP_NONE;
        end
    endfunction : mode_for

    // Power-up edge detector; bus initialise plays no part here.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            power_q <= 1'b0;
        end else begin
            power_q <= power_good_i;
        end
    end

    assign core_ok = (core_step == 2'h2) && !core_fault_i &&
                     (byte_count_reg == `LLST_PAT_ZERO);

    // Top-level sequence.
    always_comb begin
        next_state = state;
        case (state)
            LLST_ST_IDLE: begin
                if (power_good_i && !power_q) begin
                    next_state = LLST_ST_CORE;
                end
            end
            LLST_ST_CORE: begin
                if (core_step == 2'h2) begin
                    next_state = core_ok ? LLST_ST_LINES : LLST_ST_HANG;
                end
            end
            LLST_ST_LINES: begin
                if (chk_done && chan == `LLST_LAST_CHAN) begin
                    next_state = LLST_ST_EVAL;
                end
            end
            LLST_ST_EVAL: begin
                if (|chan_lamp_o && !line_fault_override_i) begin
                    next_state = LLST_ST_HANG;
                end else begin
                    next_state = LLST_ST_RUN;
                end
            end
            LLST_ST_RUN: begin
                next_state = LLST_ST_RUN;
            end
            LLST_ST_HANG: begin
                next_state = LLST_ST_HANG;
            end
            default: begin
                next_state = LLST_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= LLST_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Core self-test steps through the byte count register.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            core_step <= 2'h0;
        end else if (state == LLST_ST_CORE) begin
            if (core_step == 2'h0 ||
                (core_step == 2'h1 && byte_count_reg == `LLST_PAT_ONES)) begin
                core_step <= core_step + 2'h1;
            end else begin
                core_step <= 2'h2;
            end
        end else begin
            core_step <= 2'h0;
        end
    end

    // Board and summary lamps.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            board_fault_lamp_o <= 1'b1;
            summary_fault_lamp_o <= 1'b0;
            running_o <= 1'b0;
            hung_o <= 1'b0;
        end else begin
            if (state == LLST_ST_IDLE && next_state == LLST_ST_CORE) begin
                board_fault_lamp_o <= 1'b1;
                summary_fault_lamp_o <= 1'b0;
            end
            if (state == LLST_ST_CORE && core_ok) begin
                board_fault_lamp_o <= 1'b0;
            end
            if (state == LLST_ST_EVAL && |chan_lamp_o &&
                !line_fault_override_i) begin
                summary_fault_lamp_o <= 1'b1;
            end
            running_o <= (next_state == LLST_ST_RUN);
            hung_o <= (next_state == LLST_ST_HANG);
        end
    end

    // Host register slave; silent unless running.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            system_control_reg <= `LLST_SYS_CTRL_RST;
            byte_count_reg <= `LLST_BYTE_COUNT_RST;
            host_ack_o <= 1'b0;
            host_rdata_o <= 16'h0000;
        end else begin
            host_ack_o <= 1'b0;
            if (state == LLST_ST_CORE) begin
                if (core_step == 2'h0) begin
                    byte_count_reg <= `LLST_PAT_ONES;
                end else begin
                    byte_count_reg <= `LLST_PAT_ZERO;
                end
            end else if (bus_init_i) begin
                system_control_reg <= `LLST_SYS_CTRL_RST;
            end else if (state == LLST_ST_RUN && host_sel_i && !host_ack_o) begin
                host_ack_o <= 1'b1;
                if (host_we_i) begin
                    if (host_addr_i == `LLST_SYS_CTRL_OFS) begin
                        system_control_reg <= host_wdata_i;
                    end
                    if (host_addr_i == `LLST_BYTE_COUNT_OFS) begin
                        byte_count_reg <= host_wdata_i;
                    end
                end else begin
                    case (host_addr_i)
                        `LLST_SYS_CTRL_OFS: host_rdata_o <= system_control_reg;
                        `LLST_BYTE_COUNT_OFS: host_rdata_o <= byte_count_reg;
                        default: host_rdata_o <= 16'h0000;
                    endcase
                end
            end
        end
    end

    // Periodic selector sampling and internal-position clear requests.
    assign sample_now = (sample_cnt == SAMPLE_LAST);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sample_cnt <= 32'h00000000;
            sel_q <= 16'h0000;
            clear_adaptor <= 8'h00;
        end else begin
            clear_adaptor <= 8'h00;
            if (state != LLST_ST_RUN || sample_now) begin
                sample_cnt <= 32'h00000000;
            end else begin
                sample_cnt <= sample_cnt + 32'h00000001;
            end
            if (state == LLST_ST_RUN && sample_now) begin
                sel_q <= selector_i;
                for (int a = 0; a < `LLST_ADAPTORS; a++) begin
                    clear_adaptor[a] <=
                        sel_of(selector_i, 3'(a)) == `LLST_SEL_INT &&
                        sel_of(sel_q, 3'(a)) != `LLST_SEL_INT;
                end
            end
        end
    end

    // Channel walker: launches one check at a time.
    always_comb begin
        start = 1'b0;
        start_mode = LLST_LOOP_NONE;
        if (!pending) begin
            if (state == LLST_ST_LINES) begin
                start = 1'b1;
                start_mode = LLST_LOOP_INT;
            end else if (state == LLST_ST_RUN) begin
                start_mode = mode_for(sel_of(sel_q, adaptor_of(chan)),
                                      plug_detect_i[chan]);
                start = (start_mode != LLST_LOOP_NONE);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            chan <= 6'h00;
            pending <= 1'b0;
            test_char <= 8'h00;
            chan_o <= 6'h00;
            loop_mode_o <= LLST_LOOP_NONE;
            baud_div_o <= 16'h0000;
        end else if (state != LLST_ST_LINES && state != LLST_ST_RUN) begin
            chan <= 6'h00;
            pending <= 1'b0;
            loop_mode_o <= LLST_LOOP_NONE;
        end else if (start) begin
            pending <= 1'b1;
            chan_o <= chan;
            loop_mode_o <= start_mode;
            baud_div_o <= (start_mode == LLST_LOOP_ECHO) ? ECHO_DIV :
                          16'h0000;
            test_char <= test_char + 8'h01;
        end else if (chk_done) begin
            pending <= 1'b0;
            chan <= chan + 6'h01;
        end else if (!pending && state == LLST_ST_RUN) begin
            chan <= chan + 6'h01;
        end
    end

    // Channel lamps; a failure in the same cycle as a clear wins.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            chan_lamp_o <= 64'h0000000000000000;
        end else begin
            if (state == LLST_ST_IDLE && next_state == LLST_ST_CORE) begin
                chan_lamp_o <= 64'hFFFFFFFFFFFFFFFF;
            end
            for (int a = 0; a < `LLST_ADAPTORS; a++) begin
                if (clear_adaptor[a]) begin
                    chan_lamp_o[a*8 +: 8] <= 8'h00;
                end
            end
            if (chk_done && loop_mode_o != LLST_LOOP_ECHO &&
                loop_mode_o != LLST_LOOP_NONE) begin
                chan_lamp_o[chan] <= !chk_pass;
            end
        end
    end

    llst_chan_check u_check (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .start_i(start),
        .mode_i(start_mode),
        .char_i(test_char),
        .rx_strobe_i(rx_strobe_i),
        .rx_char_i(rx_char_i),
        .tx_strobe_o(tx_strobe_o),
        .tx_char_o(tx_char_o),
        .done_o(chk_done),
        .pass_o(chk_pass)
    );

endmodule : llst_top

// ===== verif/llst_props.sv
`timescale 1ns/1ps
module llst_props (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic power_good_i,
    input wire logic bus_init_i,
    input wire logic host_sel_i,
    input wire logic host_ack_o,
    input llst_pkg::llst_loop_t loop_mode_o,
    input wire logic [15:0] baud_div_o,
    input wire logic tx_strobe_o,
    input wire logic board_fault_lamp_o,
    input wire logic summary_fault_lamp_o,
    input wire logic running_o,
    input wire logic hung_o
);
    import llst_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    property p_ack_cycle;
        host_sel_i && running_o && !host_ack_o |=> host_ack_o ##1 !host_ack_o;
    endproperty
    a_ack_cycle: assert property (p_ack_cycle) else $error("ack late");
    property p_ack_gate;
        host_ack_o |-> $past(running_o);
    endproperty
    a_ack_gate: assert property (p_ack_gate) else $error("ack not run");
    property p_start;
        $rose(running_o) |-> $past(power_good_i, 8);
    endproperty
    a_start: assert property (p_start) else $error("run w/o power");
    property p_hang_hold;
        hung_o ##1 $stable(power_good_i) |-> hung_o;
    endproperty
    a_hang_hold: assert property (p_hang_hold) else $error("hang left");
    property p_init_run;
        running_o && bus_init_i |=> running_o ##1 running_o;
    endproperty
    a_init_run: assert property (p_init_run) else $error("init stop");
    property p_echo_baud;
        tx_strobe_o && loop_mode_o == LLST_LOOP_ECHO |-> baud_div_o == 16'h1046;
    endproperty
    a_echo_baud: assert property (p_echo_baud) else $error("baud");
    property p_tx_pulse;
        tx_strobe_o |=> !tx_strobe_o;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx len");
    property p_run_lamps;
        running_o |-> !summary_fault_lamp_o && !board_fault_lamp_o;
    endproperty
    a_run_lamps: assert property (p_run_lamps) else $error("lamp on");
endmodule : llst_props
bind llst_top llst_props u_props (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .power_good_i(power_good_i), .bus_init_i(bus_init_i),
    .host_sel_i(host_sel_i), .host_ack_o(host_ack_o),
    .loop_mode_o(loop_mode_o), .baud_div_o(baud_div_o),
    .tx_strobe_o(tx_strobe_o), .board_fault_lamp_o(board_fault_lamp_o),
    .summary_fault_lamp_o(summary_fault_lamp_o), .running_o(running_o),
    .hung_o(hung_o));

// ===== verif/llst_line_model.sv
`timescale 1ns/1ps
module llst_line_model (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic tx_strobe_i,
    input wire logic [7:0] tx_char_i,
    input wire logic [5:0] chan_i,
    input llst_pkg::llst_loop_t loop_mode_i,
    input wire logic [63:0] bad_mask_i,
    input wire logic [63:0] dead_mask_i,
    input wire logic [6:0] reply_dly_i,
    input wire logic [7:0] term_char_i,
    output logic rx_strobe_o,
    output logic [7:0] rx_char_o
);
    import llst_pkg::*;
    logic pend;
    logic [6:0] cnt;
    logic [7:0] hold;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pend <= 1'h0;
            rx_strobe_o <= 1'h0;
            rx_char_o <= 8'hA5;
        end else begin
            rx_strobe_o <= 1'h0;
            // An idle line carries no valid character.
            rx_char_o <= ~rx_char_o;
            if (tx_strobe_i && !dead_mask_i[chan_i]) begin
                pend <= 1'h1;
                cnt <= reply_dly_i;
                hold <= tx_char_i ^ {7'h00, bad_mask_i[chan_i]};
            end else if (!pend && loop_mode_i == LLST_LOOP_ECHO) begin
                pend <= 1'h1;
                cnt <= reply_dly_i;
                hold <= term_char_i;
            end else if (pend && cnt == 7'h00) begin
                pend <= 1'h0;
                rx_strobe_o <= 1'h1;
                rx_char_o <= hold;
            end else if (pend) begin
                cnt <= cnt - 7'h01;
            end
        end
    end
endmodule : llst_line_model

// ===== verif/llst_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
end
`define WAIT_FOR(c) for (w = 0; w < 3000 && !(c); w++) @(negedge core_clk_i);
module llst_top_bench;
    import llst_pkg::*;
    typedef struct {
        logic ovr;
        logic core;
        logic [63:0] bad;
        logic [63:0] dead;
        logic [6:0] dly;
        logic run;
        logic sum;
        logic [63:0] lamp;
    } llst_row_t;
    llst_row_t rows [5];
    logic core_clk_i = 1'h0, reset_i = 1'h1, power_good_i = 1'h0;
    logic bus_init_i = 1'h0, core_fault_i = 1'h0, line_fault_override_i = 1'h0;
    logic [15:0] selector_i = 16'h0000, host_wdata_i = 16'h0000;
    logic [63:0] plug_detect_i = 64'h0, bad = 64'h0, dead = 64'h0;
    logic host_sel_i = 1'h0, host_we_i = 1'h0, ok;
    logic [3:0] host_addr_i = 4'h0;
    logic rx_strobe_i, host_ack_o, tx_strobe_o, board_fault_lamp_o;
    logic summary_fault_lamp_o, running_o, hung_o;
    logic [7:0] rx_char_i, tx_char_o, term = 8'h3C;
    logic [15:0] host_rdata_o, baud_div_o, rd;
    logic [5:0] chan_o;
    logic [6:0] dly = 7'h02;
    logic [63:0] chan_lamp_o;
    llst_loop_t loop_mode_o;
    int w, i, error_cnt = 0, num_checks = 0;
    llst_top #(.SEL_SAMPLE_CYCLES(8)) DUT (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .power_good_i(power_good_i),
        .bus_init_i(bus_init_i), .core_fault_i(core_fault_i),
        .line_fault_override_i(line_fault_override_i),
        .selector_i(selector_i), .plug_detect_i(plug_detect_i),
        .host_sel_i(host_sel_i), .host_we_i(host_we_i),
        .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i),
        .rx_strobe_i(rx_strobe_i), .rx_char_i(rx_char_i),
        .host_ack_o(host_ack_o), .host_rdata_o(host_rdata_o),
        .chan_o(chan_o), .loop_mode_o(loop_mode_o), .baud_div_o(baud_div_o),
        .tx_strobe_o(tx_strobe_o), .tx_char_o(tx_char_o),
        .chan_lamp_o(chan_lamp_o), .board_fault_lamp_o(board_fault_lamp_o),
        .summary_fault_lamp_o(summary_fault_lamp_o),
        .running_o(running_o), .hung_o(hung_o));
    llst_line_model u_line (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .tx_strobe_i(tx_strobe_o), .tx_char_i(tx_char_o), .chan_i(chan_o),
        .loop_mode_i(loop_mode_o), .bad_mask_i(bad), .dead_mask_i(dead),
        .reply_dly_i(dly), .term_char_i(term), .rx_strobe_o(rx_strobe_i),
        .rx_char_o(rx_char_i));
    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic host_xfer(input logic we, input logic [3:0] a,
                             input logic [15:0] d);
        int n;
        ok = 1'h0;
        @(posedge core_clk_i);
        host_sel_i <= 1'h1;
        host_we_i <= we;
        host_addr_i <= a;
        host_wdata_i <= d;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge core_clk_i);
            ok = (host_ack_o === 1'h1);
        end
        rd = host_rdata_o;
        host_sel_i <= 1'h0;
    endtask : host_xfer
    task automatic pulse_init;
        @(posedge core_clk_i);
        bus_init_i <= 1'h1;
        @(posedge core_clk_i);
        bus_init_i <= 1'h0;
        repeat (100) @(negedge core_clk_i);
    endtask : pulse_init
    task automatic power_up(input llst_row_t r);
        @(posedge core_clk_i);
        reset_i <= 1'h1;
        power_good_i <= 1'h0;
        line_fault_override_i <= r.ovr;
        core_fault_i <= r.core;
        bad <= r.bad;
        dead <= r.dead;
        dly <= r.dly;
        selector_i <= 16'h0000;
        plug_detect_i <= 64'h0;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'h0;
        power_good_i <= 1'h1;
        for (w = 0; w < 9000 && !running_o && !hung_o; w++)
            @(negedge core_clk_i);
    endtask : power_up
    initial begin
        repeat (90000) @(posedge core_clk_i);
        error_cnt++;
        wrap_up();
    end
    initial begin
        rows[0] = '{1'h0, 1'h0, 64'h0, 64'h0, 7'h02, 1'h1, 1'h0, 64'h0};
        rows[1] = '{1'h0, 1'h0, 64'h20, 64'h0, 7'h02, 1'h0, 1'h1, 64'h20};
        rows[2] = '{1'h1, 1'h0, 64'h20, 64'h0, 7'h46, 1'h1, 1'h0, 64'h20};
        rows[3] = '{1'h1, 1'h0, 64'h0, {8'hFF, 56'h0}, 7'h02, 1'h1, 1'h0,
                    {8'hFF, 56'h0}};
        rows[4] = '{1'h1, 1'h1, 64'h0, 64'h0, 7'h02, 1'h0, 1'h0, 64'h0};
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'h0;
        pulse_init();
        `CHK("idle", 1'h0, running_o | hung_o)
        for (i = 0; i < 5; i++) begin
            power_up(rows[i]);
            `CHK("run", rows[i].run, running_o)
            `CHK("hung", !rows[i].run, hung_o)
            `CHK("summary", rows[i].sum, summary_fault_lamp_o)
            if (rows[i].core === 1'h0)
                `CHK("lamps", rows[i].lamp, chan_lamp_o)
            if (rows[i].run === 1'h1 || rows[i].core === 1'h1)
                `CHK("board", !rows[i].run, board_fault_lamp_o)
            host_xfer(1'h1, 4'h8, 16'hFFFF);
            `CHK("ack", rows[i].run, ok)
            if (ok === 1'h1) begin
                host_xfer(1'h0, 4'h8, 16'h0000);
                `CHK("bcr", 16'hFFFF, rd)
            end
        end
        power_up(rows[0]);
        host_xfer(1'h0, 4'h2, 16'h0000);
        `CHK("unmapped", 16'h0000, rd)
        pulse_init();
        `CHK("init run", 1'h1, running_o)
        @(posedge core_clk_i);
        selector_i <= 16'h0001;
        bad <= 64'h4;
        `WAIT_FOR(chan_lamp_o[2] === 1'h1)
        `CHK("int fail", 1'h1, chan_lamp_o[2])
        @(posedge core_clk_i);
        bad <= 64'h8;
        `WAIT_FOR(chan_lamp_o[3:2] === 2'h2)
        `CHK("flicker", 2'h2, chan_lamp_o[3:2])
        @(posedge core_clk_i);
        selector_i <= 16'h0000;
        repeat (200) @(negedge core_clk_i);
        `CHK("hard", 1'h1, chan_lamp_o[3])
        @(posedge core_clk_i);
        selector_i <= 16'h0008;
        plug_detect_i <= 64'hFF00;
        bad <= 64'h0;
        dead <= 64'h200;
        `WAIT_FOR(tx_strobe_o === 1'h1 && loop_mode_o === LLST_LOOP_EXT)
        `CHK("ext mode", LLST_LOOP_EXT, loop_mode_o)
        `WAIT_FOR(chan_lamp_o[9] === 1'h1)
        repeat (300) @(negedge core_clk_i);
        `CHK("ext dead", 1'h1, chan_lamp_o[9])
        `CHK("ext good", 8'h02, chan_lamp_o[15:8])
        `CHK("others", 48'h0, chan_lamp_o[63:16])
        `CHK("still run", 1'h1, running_o)
        `WAIT_FOR(tx_strobe_o === 1'h1 && chan_o === 6'h09)
        @(posedge core_clk_i);
        selector_i <= 16'h0004;
        `WAIT_FOR(chan_lamp_o[15:8] === 8'h00)
        `CHK("int clear", 8'h00, chan_lamp_o[15:8])
        @(posedge core_clk_i);
        selector_i <= 16'h0008;
        plug_detect_i <= 64'h0;
        dead <= 64'h0;
        `WAIT_FOR(tx_strobe_o === 1'h1 && loop_mode_o === LLST_LOOP_ECHO)
        `CHK("echo char", 8'h3C, tx_char_o)
        `CHK("echo baud", 16'h1046, baud_div_o)
        wrap_up();
    end
endmodule : llst_top_bench
